// *** include/tsc_pkg.sv ***
// Shared constants for the temperature sensor conversion control block
`default_nettype none

package tsc_pkg;

	// ==============================================================
	// Clock and time base
	localparam int CLK_HZ      = 125_000_000;
	localparam int TICK_US     = 1000;
	localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;

	// ==============================================================
	// Longest conversion time per resolution, and nonvolatile write time, in ms
	localparam logic [7:0] CONV_MS_9BIT  = 8'h19;
	localparam logic [7:0] CONV_MS_10BIT = 8'h32;
	localparam logic [7:0] CONV_MS_11BIT = 8'h64;
	localparam logic [7:0] CONV_MS_12BIT = 8'hC8;
	localparam logic [7:0] NV_WRITE_MS   = 8'h0A;

	// ==============================================================
	// Register addresses seen by the serial engine
	localparam logic [7:0] ADDR_CFG_RD = 8'h00;
	localparam logic [7:0] ADDR_CFG_WR = 8'h80;

	// ==============================================================
	// Configuration/status field positions
	localparam int BIT_SHUTDOWN     = 0;
	localparam int BIT_RES_LO       = 1;
	localparam int BIT_RES_HI       = 2;
	localparam int BIT_THERMO       = 3;
	localparam int BIT_ONESHOT      = 4;
	localparam int BIT_NV_PENDING   = 5;
	localparam int BIT_WRITE_TARGET = 6;

	// ==============================================================
	// Factory power-up values
	localparam logic       SHUTDOWN_RESET = 1'b1;
	localparam logic [1:0] RES_RESET      = 2'b00;
	localparam logic       THERMO_RESET   = 1'b0;
	localparam logic [7:0] CFG_RESET      = 8'h01;

	// ==============================================================
	// Conversion sequencer states, Gray on every step except STORE to SHUTDOWN
	typedef enum logic [1:0] {
		ST_SHUTDOWN = 2'b00,
		ST_CONVERT  = 2'b01,
		ST_STORE    = 2'b11
	} tsc_state_t;

endpackage

`default_nettype wire

// *** hdl/tsc_ms_timer.sv ***
// Millisecond interval timer: one start pulse, one done pulse after limit_ms
`timescale 1ns/1ps
`default_nettype none

module tsc_ms_timer #(
	parameter int TICK_CYCLES = tsc_pkg::TICK_CYCLES
) (
	input  wire logic       sys_clk,   // System clock
	input  wire logic       sys_rst,   // Synchronous reset, active high
	input  wire logic       start,     // Start pulse, restarts a running interval
	input  wire logic [7:0] limit_ms,  // Interval length in ms
	output logic            done       // One-cycle pulse at interval end
);

	// ==============================================================
	// Elaboration check
	if (TICK_CYCLES < 1) begin : g_bad_tick
		$error("TICK_CYCLES must be at least 1");
	end

	logic        running;
	logic [31:0] tick_cnt;
	logic [7:0]  ms_cnt;
	logic [7:0]  limit;
	logic        tick;

	assign tick = running && (tick_cnt == 32'(TICK_CYCLES - 1));

	// ==============================================================
	// Divider and interval count
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			running  <= 1'b0;
			tick_cnt <= 32'h0000_0000;
			ms_cnt   <= 8'h00;
			limit    <= 8'h00;
			done     <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				running  <= (limit_ms != 8'h00);
				done     <= (limit_ms == 8'h00);
				tick_cnt <= 32'h0000_0000;
				ms_cnt   <= 8'h00;
				limit    <= limit_ms;
			end else if (running) begin
				tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
				if (tick) begin
					ms_cnt <= ms_cnt + 8'h01;
					if (ms_cnt + 8'h01 == limit) begin
						running <= 1'b0;
						done    <= 1'b1;
					end
				end
			end
		end
	end

	// ==============================================================
	// Checks
	logic [39:0] elapsed;

	always_ff @(posedge sys_clk) begin
		if (sys_rst || start) begin
			elapsed <= 40'h00_0000_0000;
		end else begin
			elapsed <= elapsed + 40'h00_0000_0001;
		end
	end

	a_interval_length: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(done && limit != 8'h00) |-> elapsed == 40'(limit) * 40'(TICK_CYCLES))
		else $error("Interval did not last limit_ms milliseconds");

endmodule

`default_nettype wire

// *** hdl/tsc_conv_ctrl.sv ***
// Conversion configuration/status register and conversion sequencer
//
// Notes on behaviour
// - Two-bit resolution field, factory value 00, held as a nonvolatile setting.
// - Codes 00..11 give 9..12 bits within 25, 50, 100, 200 ms; host-writable.
// - Shutdown select is bit 0, factory value 1, host read/write, nonvolatile.
// - Shutdown select 0 converts back to back, storing each finished result.
// - Setting shutdown finishes and stores the running conversion, then shuts down.
// - The serial register port keeps working while shut down.
// - One-shot does exactly one conversion, stores it, returns to shutdown.
`timescale 1ns/1ps
`default_nettype none

module tsc_conv_ctrl #(
	parameter int TICK_CYCLES = tsc_pkg::TICK_CYCLES
) (
	input  wire logic        sys_clk,                  // System clock, 125 MHz
	input  wire logic        sys_rst,                  // Synchronous reset, active high
	input  wire logic        reg_wr_stb,               // Register write strobe from serial engine
	input  wire logic [7:0]  reg_addr,                 // Register address byte
	input  wire logic [7:0]  reg_wr_data,              // Register write data
	input  wire logic        serial_busy,              // Serial transfer in progress
	input  wire logic        serial_format_select_pin, // Format pin, asynchronous
	input  wire logic [11:0] sensor_sample,            // Front-end result, valid at conversion end
	output logic [7:0]       config_status,            // Configuration/status read value
	output logic [15:0]      temp_value,               // Temperature register
	output logic             adc_start,                // Front-end start pulse
	output logic             low_power,                // Shutdown state reached
	output logic             lsb_first,                // Serial bytes go LSB first
	output logic             nv_write_strobe           // Commit configuration to nonvolatile store
);

	// ==============================================================
	// Elaboration check
	if (TICK_CYCLES < 1) begin : g_bad_tick
		$error("TICK_CYCLES must be at least 1");
	end

	tsc_pkg::tsc_state_t state;

	logic       shutdown_select;
	logic [1:0] resolution_select;
	logic       thermostat_behaviour_select;
	logic       config_write_target_select;
	logic       single_conversion_trigger;
	logic       nonvolatile_write_pending;
	logic [7:0] conv_limit_ms;
	logic       conv_done;
	logic       nv_done;
	logic       cfg_wr;
	logic       store_now;
	logic [2:0] fmt_sync;

	// Writes are refused while a nonvolatile commit runs, so the stored image stays whole
	assign cfg_wr    = reg_wr_stb && (reg_addr == tsc_pkg::ADDR_CFG_WR) && !nonvolatile_write_pending;
	// Result waits for an idle serial port so a read never sees a torn value
	assign store_now = (state == tsc_pkg::ST_STORE) && !serial_busy;

	// ==============================================================
	// Configuration fields, writable in every state
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			shutdown_select             <= tsc_pkg::SHUTDOWN_RESET;
			resolution_select           <= tsc_pkg::RES_RESET;
			thermostat_behaviour_select <= tsc_pkg::THERMO_RESET;
			config_write_target_select  <= 1'b0;
		end else if (cfg_wr) begin
			shutdown_select             <= reg_wr_data[tsc_pkg::BIT_SHUTDOWN];
			resolution_select           <= reg_wr_data[tsc_pkg::BIT_RES_HI:tsc_pkg::BIT_RES_LO];
			thermostat_behaviour_select <= reg_wr_data[tsc_pkg::BIT_THERMO];
			config_write_target_select  <= reg_wr_data[tsc_pkg::BIT_WRITE_TARGET];
		end
	end

	// ==============================================================
	// Single-conversion trigger; a new set beats the completion clear
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			single_conversion_trigger <= 1'b0;
		end else if (cfg_wr && shutdown_select && reg_wr_data[tsc_pkg::BIT_ONESHOT]) begin
			single_conversion_trigger <= 1'b1;
		end else if (store_now || (cfg_wr && shutdown_select)) begin
			single_conversion_trigger <= 1'b0;
		end
	end

	// ==============================================================
	// Nonvolatile commit
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			nonvolatile_write_pending <= 1'b0;
			nv_write_strobe           <= 1'b0;
		end else begin
			nv_write_strobe <= cfg_wr && reg_wr_data[tsc_pkg::BIT_WRITE_TARGET];
			if (cfg_wr && reg_wr_data[tsc_pkg::BIT_WRITE_TARGET]) begin
				nonvolatile_write_pending <= 1'b1;
			end else if (nv_done) begin
				nonvolatile_write_pending <= 1'b0;
			end
		end
	end

	tsc_ms_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_nv_timer (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.start    (nv_write_strobe),
		.limit_ms (tsc_pkg::NV_WRITE_MS),
		.done     (nv_done)
	);

	// ==============================================================
	// Conversion sequencer
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state         <= tsc_pkg::ST_SHUTDOWN;
			adc_start     <= 1'b0;
			conv_limit_ms <= tsc_pkg::CONV_MS_9BIT;
		end else begin
			adc_start <= 1'b0;
			unique case (state)
				tsc_pkg::ST_SHUTDOWN: begin
					if (!shutdown_select || single_conversion_trigger) begin
						state     <= tsc_pkg::ST_CONVERT;
						adc_start <= 1'b1;
					end
				end
				tsc_pkg::ST_CONVERT: begin
					// Shutdown select is not looked at here: a running conversion always ends
					if (conv_done) begin
						state <= tsc_pkg::ST_STORE;
					end
				end
				tsc_pkg::ST_STORE: begin
					if (store_now) begin
						if (!shutdown_select) begin
							state     <= tsc_pkg::ST_CONVERT;
							adc_start <= 1'b1;
						end else begin
							state <= tsc_pkg::ST_SHUTDOWN;
						end
					end
				end
				default: begin
					state <= tsc_pkg::ST_SHUTDOWN;
				end
			endcase
			if (state != tsc_pkg::ST_CONVERT) begin
				unique case (resolution_select)
					2'b00: conv_limit_ms <= tsc_pkg::CONV_MS_9BIT;
					2'b01: conv_limit_ms <= tsc_pkg::CONV_MS_10BIT;
					2'b10: conv_limit_ms <= tsc_pkg::CONV_MS_11BIT;
					2'b11: conv_limit_ms <= tsc_pkg::CONV_MS_12BIT;
				endcase
			end
		end
	end

	tsc_ms_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_conv_timer (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.start    (adc_start),
		.limit_ms (conv_limit_ms),
		.done     (conv_done)
	);

	// ==============================================================
	// Temperature register, unused low bits zero at lower resolutions
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			temp_value <= 16'h0000;
		end else if (store_now) begin
			temp_value <= {sensor_sample, 4'h0} & (16'hFFFF << (3'd7 - {1'b0, resolution_select}));
		end
	end

	// ==============================================================
	// Status outputs, one cycle behind the fields
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			config_status <= tsc_pkg::CFG_RESET;
			low_power     <= 1'b1;
		end else begin
			config_status <= {1'b0, config_write_target_select, nonvolatile_write_pending,
				single_conversion_trigger, thermostat_behaviour_select, resolution_select,
				shutdown_select};
			low_power     <= (state == tsc_pkg::ST_SHUTDOWN);
		end
	end

	// ==============================================================
	// Format pin: three stages, a change counts once stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			// Pin level that gives lsb_first 0 at reset, so no false change follows reset
			fmt_sync  <= 3'b111;
			lsb_first <= 1'b0;
		end else begin
			fmt_sync <= {fmt_sync[1:0], serial_format_select_pin};
			if (fmt_sync[1] == fmt_sync[2]) begin
				lsb_first <= !fmt_sync[2];
			end
		end
	end

	// ==============================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_res_factory: assert property ($past(sys_rst) |-> resolution_select == tsc_pkg::RES_RESET
		&& !nonvolatile_write_pending)
		else $error("Resolution not 00 after reset");
	// The limit was latched on the same edge that raised the pulse, from the field as it stood then
	a_limit_table: assert property (adc_start |-> conv_limit_ms ==
		($past(resolution_select) == 2'b00 ? tsc_pkg::CONV_MS_9BIT :
		$past(resolution_select) == 2'b01 ? tsc_pkg::CONV_MS_10BIT :
		$past(resolution_select) == 2'b10 ? tsc_pkg::CONV_MS_11BIT : tsc_pkg::CONV_MS_12BIT))
		else $error("Conversion limit does not match resolution");
	a_shutdown_factory: assert property ($past(sys_rst) |-> shutdown_select ##1
		config_status == tsc_pkg::CFG_RESET)
		else $error("Shutdown select not 1 after reset");
	a_back_to_back: assert property ((store_now && !shutdown_select) |=>
		adc_start && state == tsc_pkg::ST_CONVERT && temp_value[15:7] == $past(sensor_sample[11:3])
		##1 !adc_start)
		else $error("Continuous mode did not restart conversion");
	a_finish_first: assert property ((state == tsc_pkg::ST_CONVERT && !conv_done) |=>
		state == tsc_pkg::ST_CONVERT)
		else $error("Conversion abandoned before completion");
	a_port_in_shutdown: assert property ((cfg_wr && state == tsc_pkg::ST_SHUTDOWN) |=>
		shutdown_select == $past(reg_wr_data[tsc_pkg::BIT_SHUTDOWN]) ##1
		config_status[0] == $past(reg_wr_data[tsc_pkg::BIT_SHUTDOWN], 2))
		else $error("Register write lost in shutdown");
	a_one_shot_end: assert property ((store_now && shutdown_select) |=>
		state == tsc_pkg::ST_SHUTDOWN ##1 low_power)
		else $error("One-shot did not return to shutdown");
	a_trigger_ignored: assert property ((!shutdown_select && !single_conversion_trigger) |=>
		!single_conversion_trigger)
		else $error("Trigger set during continuous conversion");
	a_trigger_clears: assert property ((store_now && !(cfg_wr && reg_wr_data[tsc_pkg::BIT_ONESHOT])) |=>
		!single_conversion_trigger)
		else $error("Trigger did not clear at completion");

	c_one_shot: cover property (single_conversion_trigger ##1 adc_start);
	c_continuous: cover property (store_now && !shutdown_select);
	c_enter_shutdown: cover property (store_now && shutdown_select && !single_conversion_trigger);
	c_nv_commit: cover property (nv_done);

endmodule

`default_nettype wire

// *** bench/tsc_host_model.sv ***
// Host model: serial master side that hands configuration writes to the block
`timescale 1ns/1ps
`default_nettype none

module tsc_host_model (
	input  wire logic       sys_clk,     // System clock
	output logic            reg_wr_stb,  // Write strobe, one cycle per byte
	output logic [7:0]      reg_addr,    // Address byte
	output logic [7:0]      reg_wr_data, // Write data
	output logic            serial_busy  // Transfer active
);
	// ==========================================================
	// Idle bus
	// Released lines show the inverse of the last byte, so a stale value never looks valid
	initial begin
		reg_wr_stb  = 1'b0;
		reg_addr    = 8'h00;
		reg_wr_data = 8'h00;
		serial_busy = 1'b0;
	end

	// ==========================================================
	// One-byte write transfer
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge sys_clk);
		serial_busy = 1'b1;
		reg_wr_stb  = 1'b1;
		reg_addr    = addr;
		reg_wr_data = data;
		@(negedge sys_clk);
		reg_wr_stb  = 1'b0;
		reg_addr    = ~addr;
		reg_wr_data = ~data;
		serial_busy = 1'b0;
	endtask
endmodule

`default_nettype wire

// *** bench/tb.sv ***
// Testbench for the conversion configuration and sequencer block
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam int TK = 2;

	logic        sys_clk, sys_rst, reg_wr_stb, serial_busy, fmt_pin;
	logic        adc_start, low_power, lsb_first, nv_write_strobe, lp_prev;
	logic [7:0]  reg_addr, reg_wr_data, config_status;
	logic [11:0] sample;
	logic [15:0] temp_value;
	int          err_count, checked, cyc, st_cyc, prev_st, lp_cyc, starts, nv_pulses, k;
	int          lim [4];

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	tsc_host_model i_host (.sys_clk(sys_clk), .reg_wr_stb(reg_wr_stb), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .serial_busy(serial_busy));

	tsc_conv_ctrl #(.TICK_CYCLES(TK)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr_stb(reg_wr_stb),
		.reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .serial_busy(serial_busy),
		.serial_format_select_pin(fmt_pin), .sensor_sample(sample), .config_status(config_status),
		.temp_value(temp_value), .adc_start(adc_start), .low_power(low_power), .lsb_first(lsb_first),
		.nv_write_strobe(nv_write_strobe));

	// ==========================================================
	// Event monitor: both edges are stamped the same way, so differences are exact
	always @(posedge sys_clk) begin
		cyc++;
		if (adc_start === 1'b1) begin
			prev_st = st_cyc;
			st_cyc  = cyc;
			starts++;
		end
		if (low_power === 1'b1 && lp_prev !== 1'b1)
			lp_cyc = cyc;
		lp_prev = low_power;
		if (nv_write_strobe === 1'b1)
			nv_pulses++;
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.write_reg(a, d);
		repeat (2) @(negedge sys_clk);
	endtask

	task automatic wait_lp();
		lp_cyc = 0;
		for (int i = 0; i < 3000 && lp_cyc == 0; i++)
			@(negedge sys_clk);
		if (lp_cyc == 0)
			err_count++;
	endtask

	task automatic wait_start(input int n);
		for (int i = 0; i < 3000 && starts < n; i++)
			@(negedge sys_clk);
		if (starts < n)
			err_count++;
	endtask

	function automatic logic [15:0] exp_temp(input logic [1:0] res, input logic [11:0] s);
		return {s & (12'hFFF << (2'd3 - res)), 4'h0};
	endfunction

	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Longest run is a few thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		finish_test();
	end

	// ==========================================================
	// Test sequence
	initial begin
		sys_rst = 1'b1;
		fmt_pin = 1'b1;
		sample = 12'hFFF;
		lim = '{tsc_pkg::CONV_MS_9BIT, tsc_pkg::CONV_MS_10BIT, tsc_pkg::CONV_MS_11BIT, tsc_pkg::CONV_MS_12BIT};
		{err_count, checked, cyc, st_cyc, prev_st, lp_cyc, starts, nv_pulses} = '0;
		lp_prev = 1'b0;
		repeat (6) @(negedge sys_clk);
		sys_rst = 1'b0;
		check("cfg_reset", config_status, 16'h0001);
		check("temp_reset", temp_value, 16'h0000);
		check("lp_reset", low_power, 16'h0001);
		repeat (2) @(negedge sys_clk);
		check("lsb_reset", lsb_first, 16'h0000);
		repeat (98) @(negedge sys_clk);
		check("idle_starts", 16'(starts), 16'h0000);
		$display("test reset done");

		for (int r = 0; r < 4; r++) begin
			k = starts;
			wr(8'h80, {3'b000, 1'b1, 1'b0, r[1:0], 1'b1});
			check("cfg_trigger", config_status, {11'h000, 1'b1, 1'b0, r[1:0], 1'b1});
			wait_lp();
			check("conv_time", 16'(lp_cyc - st_cyc), 16'(lim[r] * TK + 4));
			check("temp_res", temp_value, exp_temp(r[1:0], sample));
			repeat (20) @(negedge sys_clk);
			check("one_start", 16'(starts - k), 16'h0001);
			check("trig_clear", config_status[4], 16'h0000);
		end
		$display("test one-shot done");

		k = starts;
		sample = 12'h5A3;
		wr(8'h80, 8'h06);
		check("cfg_cont", config_status, 16'h0006);
		wait_start(k + 2);
		check("cont_period", 16'(st_cyc - prev_st), 16'(lim[3] * TK + 3));
		check("cont_temp", temp_value, exp_temp(2'b11, 12'h5A3));
		repeat (10) @(negedge sys_clk);
		wr(8'h80, 8'h07);
		sample = 12'h3C7;
		wait_lp();
		check("sd_finish", 16'(lp_cyc - st_cyc), 16'(lim[3] * TK + 4));
		check("sd_temp", temp_value, exp_temp(2'b11, 12'h3C7));
		k = starts;
		repeat (50) @(negedge sys_clk);
		check("sd_quiet", 16'(starts - k), 16'h0000);
		$display("test continuous done");

		// Go continuous first: the trigger is only refused while shutdown select is 0
		wr(8'h80, 8'h00);
		wr(8'h80, 8'h10);
		check("trig_ignored", config_status, 16'h0000);
		wr(8'h80, 8'h01);
		wait_lp();
		check("sd_port", config_status, 16'h0001);
		wr(8'h83, 8'h06);
		check("other_addr", config_status, 16'h0001);
		k = nv_pulses;
		wr(8'h80, 8'h41);
		check("nv_strobe", 16'(nv_pulses - k), 16'h0001);
		check("nv_pending", config_status[5], 16'h0001);
		wr(8'h80, 8'h05);
		check("nv_drop", config_status[2:0], 16'h0001);
		repeat (30) @(negedge sys_clk);
		check("nv_done", config_status[5], 16'h0000);
		$display("test register port done");

		check("msb_first", lsb_first, 16'h0000);
		fmt_pin = 1'b0;
		repeat (6) @(negedge sys_clk);
		check("lsb_first", lsb_first, 16'h0001);
		$display("test format done");
		finish_test();
	end
endmodule

`default_nettype wire
